// file: rpmc_pkg.sv
package rpmc_pkg;
   // Register byte offsets
   localparam logic [7:0] A_MODE = 8'h00;   // Operating mode control
   localparam logic [7:0] A_OPT  = 8'h04;   // Options
   localparam logic [7:0] A_PA   = 8'h08;   // Amplifier power step
   localparam logic [7:0] A_STAT = 8'h0C;   // Status, read only
   localparam logic [7:0] A_RXD  = 8'h10;   // Receive FIFO head, read pops
   localparam logic [7:0] A_GPIO = 8'h14;   // Pin drive and level
   // Mode register bits
   localparam int MB_XTON = 0;              // Ready
   localparam int MB_PLL  = 1;              // Tuning
   localparam int MB_RXON = 2;              // Receive request
   localparam int MB_TXON = 3;              // Transmit request
   localparam int MB_SENS = 5;              // Sensor, auxiliary group
   localparam int MB_WT   = 6;              // Wake timer, sleep
   localparam int MB_SWRST = 7;             // Software reset, self clearing
   localparam logic [7:0] MODE_RST = 8'h01; // Ready after any reset
   // Option register bits
   localparam int OB_OSC = 0;               // Optional oscillator on
   localparam int OB_AUX = 1;               // Optional auxiliary on
   localparam int OB_GAUSS = 2;             // Gaussian shaping on
   localparam int OB_ROUTE = 3;             // Receive data to pin 0
   localparam logic [3:0] OPT_RST = 4'h0;
   localparam logic [2:0] PA_RST  = 3'h7;   // Highest step
   localparam int PA_STEP_DB = 3;           // Step size of one code
   // Timing
   localparam int CLK_NS   = 10;
   localparam int XTAL_NS  = 1000;          // Crystal start wait
   localparam int PLL_NS   = 500;           // Synthesizer settle wait
   localparam int RAMP_NS  = 200;           // Amplifier ramp time
   localparam int XTAL_CYC = (XTAL_NS + CLK_NS - 1) / CLK_NS;
   localparam int PLL_CYC  = (PLL_NS + CLK_NS - 1) / CLK_NS;
   localparam int RAMP_CYC = (RAMP_NS + CLK_NS - 1) / CLK_NS;
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 64;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_SHUT = 3'b000, ST_IDLE = 3'b001, ST_XTAL = 3'b010, ST_PLL = 3'b011,
      ST_RUP  = 3'b100, ST_TX   = 3'b101, ST_RX   = 3'b110, ST_RDN = 3'b111
   } rpmc_state_e;
   // Power enables of every internal block
   typedef struct packed {
      logic lp_reg;    // low_power_regulator
      logic main_reg;  // Main digital regulator
      logic spi;       // Serial logic and register space
      logic osc32;     // Low-frequency oscillator and wake timer
      logic aux;       // Temperature, converter, battery detector
      logic xtal;      // Crystal
      logic pll;       // Synthesizer
      logic pa;        // Amplifier
      logic rx;        // Receiver
   } rpmc_pwr_s;
   // Demodulated byte stream
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } rpmc_byte_s;
endpackage

// file: rpmc_top.sv
`timescale 1ns/1ps
// Receive byte FIFO with valid and ready on both sides
module rpmc_fifo #(
   parameter int W = 8,
   parameter int D = 64
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         flush,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   // Whole state of the FIFO
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } rpmc_fifo_s;
   rpmc_fifo_s s_q, s_d;
   logic push, pop;

   assign in_ready  = (s_q.cnt != (AW+1)'(D));
   assign out_valid = (s_q.cnt != '0);
   assign out_data  = s_q.mem[s_q.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointer and count update
   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (pop)
         s_d.rp = s_q.rp + 1'b1;
      if (push & ~pop)
         s_d.cnt = s_q.cnt + 1'b1;
      else if (pop & ~push)
         s_d.cnt = s_q.cnt - 1'b1;
      if (flush)
      begin
         s_d.wp  = '0;
         s_d.rp  = '0;
         s_d.cnt = '0;
      end
   end

   // State register
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule // rpmc_fifo

`timescale 1ns/1ps
// Radio operating-mode controller with AHB-Lite register slave
module rpmc_top (
   input  wire logic              CLOCK,
   input  wire logic              ARST_N,
   input  wire logic              HSEL,
   input  wire logic [31:0]       HADDR,
   input  wire logic [1:0]        HTRANS,
   input  wire logic              HWRITE,
   input  wire logic [2:0]        HSIZE,
   input  wire logic [31:0]       HWDATA,
   input  wire logic              HREADY,
   output logic                   HREADYOUT,
   output logic [31:0]            HRDATA,
   output logic                   HRESP,
   input  wire logic              SHUTDOWN_PIN,
   input  wire rpmc_pkg::rpmc_byte_s RX_IN,
   output logic                   RX_READY,
   input  wire logic              RX_BIT,
   input  wire logic              TX_BIT,
   output logic [2:0]             TX_MOD,
   output rpmc_pkg::rpmc_pwr_s    PWR,
   output logic [2:0]             PA_LEVEL,
   output logic [7:0]             PA_RAMP,
   input  wire logic [2:0]        GPIO_I,
   output logic [2:0]             GPIO_O,
   output logic [2:0]             GPIO_OE
);
   // Whole state of the controller
   typedef struct packed {
      logic [1:0]          sdn_sync;  // Shutdown pin synchroniser
      logic [1:0][2:0]     gpi_sync;  // Pin input synchroniser
      rpmc_pkg::rpmc_state_e st;      // Sequencer state
      logic [7:0]          mode;      // Mode control
      logic [3:0]          opt;       // Options
      logic [2:0]          pa_lvl;    // Amplifier power step
      logic [2:0]          gp_out;    // Pin drive values
      logic [2:0]          gp_oe;     // Pin drive enables
      logic [7:0]          tmr;       // Wait timer
      logic [7:0]          ramp;      // Amplifier ramp level
      logic [2:0]          gshift;    // Transmit bit history
      logic [2:0]          tx_mod;    // Shaped transmit value
      logic                dp_wr;     // Write data phase pending
      logic [7:0]          dp_addr;   // Address of that write
      logic [31:0]         rdata;     // Read data register
      rpmc_pkg::rpmc_pwr_s pwr;       // Block power enables
      logic [2:0]          gpio_o;    // Pin outputs
   } rpmc_s;
   rpmc_s s_q, s_d;

   logic       shut;       // Synchronised shutdown level
   logic       ap_valid;   // Address phase taken
   logic [7:0] ap_addr;    // Word address of the phase
   logic       rx_pop;     // Register read pops FIFO
   logic       f_valid;    // FIFO holds data
   logic [7:0] f_data;     // FIFO head
   logic       f_in_valid; // Byte offered to FIFO
   logic       f_in_ready; // FIFO has room
   logic       tx_req;     // Transmit requested
   logic       rx_req;     // Receive requested

   // Offset match, used by read and write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign shut     = s_q.sdn_sync[1];
   assign ap_valid = HSEL & HTRANS[1] & HREADY;
   assign ap_addr  = {HADDR[7:2], 2'b00};
   assign rx_pop   = ap_valid & ~HWRITE & ~shut & hit(ap_addr, rpmc_pkg::A_RXD)
                     & f_valid;
   assign tx_req   = s_q.mode[rpmc_pkg::MB_TXON];
   assign rx_req   = s_q.mode[rpmc_pkg::MB_RXON] & ~tx_req;
   // Receive bits go to the pin instead when routed
   assign f_in_valid = RX_IN.valid & ~s_q.opt[rpmc_pkg::OB_ROUTE] & (s_q.st == rpmc_pkg::ST_RX);
   // Back-pressure reaches the demodulator; routed or idle bytes are dropped
   assign RX_READY = f_in_ready | s_q.opt[rpmc_pkg::OB_ROUTE] | (s_q.st != rpmc_pkg::ST_RX);

   // Receive FIFO, emptied by register reads
   rpmc_fifo #(
      .W (rpmc_pkg::FIFO_W),
      .D (rpmc_pkg::FIFO_D)
   ) u_fifo (
      .clk       (CLOCK),
      .arst_n    (ARST_N),
      .flush     (shut),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (RX_IN.data),
      .out_valid (f_valid),
      .out_ready (rx_pop),
      .out_data  (f_data)
   );

   // Next-state logic: bus, sequencer, enables
   always_comb
   begin
      s_d = s_q;
      s_d.sdn_sync = {s_q.sdn_sync[0], SHUTDOWN_PIN};
      s_d.gpi_sync = {s_q.gpi_sync[0], GPIO_I};
      s_d.dp_wr = 1'b0;
      // Address phase: capture write, register read data
      if (ap_valid)
      begin
         s_d.dp_wr   = HWRITE;
         s_d.dp_addr = ap_addr;
         s_d.rdata   = 32'h0000_0000;
         if (!HWRITE)
         begin
            if (hit(ap_addr, rpmc_pkg::A_MODE))
               s_d.rdata = {24'h00_0000, s_q.mode};
            else if (hit(ap_addr, rpmc_pkg::A_OPT))
               s_d.rdata = {28'h000_0000, s_q.opt};
            else if (hit(ap_addr, rpmc_pkg::A_PA))
               s_d.rdata = {29'h0000_0000, s_q.pa_lvl};
            else if (hit(ap_addr, rpmc_pkg::A_STAT))
               s_d.rdata = {19'h0_0000, f_valid, s_q.st, s_q.pwr};
            else if (hit(ap_addr, rpmc_pkg::A_RXD))
               // Empty FIFO reads zero, never a stale byte left at the read pointer
               s_d.rdata = {23'h00_0000, f_valid, (f_valid ? f_data : 8'h00)};
            else if (hit(ap_addr, rpmc_pkg::A_GPIO))
               s_d.rdata = {23'h00_0000, s_q.gpi_sync[1], s_q.gp_oe, s_q.gp_out};
            // Unmapped reads return zero
         end
      end
      // Data phase of a write
      if (s_q.dp_wr)
      begin
         if (hit(s_q.dp_addr, rpmc_pkg::A_MODE))
            s_d.mode = HWDATA[7:0];
         else if (hit(s_q.dp_addr, rpmc_pkg::A_OPT))
            s_d.opt = HWDATA[3:0];
         else if (hit(s_q.dp_addr, rpmc_pkg::A_PA))
            s_d.pa_lvl = HWDATA[2:0];
         else if (hit(s_q.dp_addr, rpmc_pkg::A_GPIO))
         begin
            s_d.gp_out = HWDATA[2:0];
            s_d.gp_oe  = HWDATA[5:3];
         end
      end
      // Software reset restores every writable register and ready mode
      if (s_q.mode[rpmc_pkg::MB_SWRST])
      begin
         s_d.mode   = rpmc_pkg::MODE_RST;
         s_d.opt    = rpmc_pkg::OPT_RST;
         s_d.pa_lvl = rpmc_pkg::PA_RST;
         s_d.gp_out = 3'h0;
         s_d.gp_oe  = 3'h0;
         s_d.st     = rpmc_pkg::ST_IDLE;
      end
      // Sequencer
      case (s_q.st)
         rpmc_pkg::ST_SHUT:
            s_d.st = rpmc_pkg::ST_IDLE;
         rpmc_pkg::ST_IDLE:
         begin
            s_d.tmr = 8'h00;
            if (tx_req | rx_req)
            begin
               if (!(s_q.mode[rpmc_pkg::MB_XTON] | s_q.mode[rpmc_pkg::MB_PLL]))
                  s_d.st = rpmc_pkg::ST_XTAL;
               else if (!s_q.mode[rpmc_pkg::MB_PLL])
                  s_d.st = rpmc_pkg::ST_PLL;
               else
                  s_d.st = tx_req ? rpmc_pkg::ST_RUP : rpmc_pkg::ST_RX;
            end
         end
         rpmc_pkg::ST_XTAL:
         begin
            s_d.tmr = s_q.tmr + 8'h01;
            if (s_q.tmr == 8'(rpmc_pkg::XTAL_CYC - 1))
            begin
               s_d.tmr = 8'h00;
               s_d.st  = rpmc_pkg::ST_PLL;
            end
         end
         rpmc_pkg::ST_PLL:
         begin
            s_d.tmr = s_q.tmr + 8'h01;
            if (s_q.tmr == 8'(rpmc_pkg::PLL_CYC - 1))
            begin
               s_d.tmr = 8'h00;
               if (tx_req)
                  s_d.st = rpmc_pkg::ST_RUP;
               else if (rx_req)
                  s_d.st = rpmc_pkg::ST_RX;
               else
                  s_d.st = rpmc_pkg::ST_IDLE;
            end
         end
         rpmc_pkg::ST_RUP:
         begin
            s_d.ramp = s_q.ramp + 8'h01;
            if (s_q.ramp == 8'(rpmc_pkg::RAMP_CYC - 1))
               s_d.st = rpmc_pkg::ST_TX;
         end
         rpmc_pkg::ST_TX:
            if (!tx_req)
               s_d.st = rpmc_pkg::ST_RDN;
         rpmc_pkg::ST_RDN:
         begin
            s_d.ramp = s_q.ramp - 8'h01;
            if (s_q.ramp == 8'h01)
               s_d.st = rpmc_pkg::ST_IDLE;
         end
         rpmc_pkg::ST_RX:
            // Leave receive before any transmit may start
            if (!rx_req)
               s_d.st = rpmc_pkg::ST_IDLE;
         default:
            s_d.st = rpmc_pkg::ST_IDLE;
      endcase
      // Transmit shaping: 1-2-1 filter over last three bits
      s_d.gshift = {s_q.gshift[1:0], TX_BIT};
      if (s_q.st != rpmc_pkg::ST_TX)
         s_d.tx_mod = 3'h0;
      else if (s_q.opt[rpmc_pkg::OB_GAUSS])
         s_d.tx_mod = 3'(s_q.gshift[2]) + {1'b0, s_q.gshift[1], 1'b0}
                      + 3'(s_q.gshift[0]);
      else
         s_d.tx_mod = {s_q.gshift[0], 2'b00};
      // Pins: pin 0 may carry receive data
      s_d.gpio_o = s_q.gp_out;
      if (s_q.opt[rpmc_pkg::OB_ROUTE])
         s_d.gpio_o[0] = RX_BIT;
      // Shutdown wins over everything and loses all contents
      if (shut)
      begin
         s_d = '0;
         s_d.sdn_sync = {s_q.sdn_sync[0], SHUTDOWN_PIN};
         s_d.gpi_sync = {s_q.gpi_sync[0], GPIO_I};
         s_d.mode   = rpmc_pkg::MODE_RST;
         s_d.pa_lvl = rpmc_pkg::PA_RST;
         s_d.st     = rpmc_pkg::ST_SHUT;
      end
      // Power enables follow the next mode and state
      s_d.pwr = '0;
      if (s_d.st != rpmc_pkg::ST_SHUT)
      begin
         s_d.pwr.lp_reg = 1'b1;
         s_d.pwr.spi    = 1'b1;
         s_d.pwr.xtal   = s_d.mode[rpmc_pkg::MB_XTON] | s_d.mode[rpmc_pkg::MB_PLL]
                          | (s_d.st != rpmc_pkg::ST_IDLE);
         s_d.pwr.main_reg = s_d.pwr.xtal;
         s_d.pwr.pll    = s_d.mode[rpmc_pkg::MB_PLL] | ((s_d.st != rpmc_pkg::ST_IDLE)
                          & (s_d.st != rpmc_pkg::ST_XTAL));
         s_d.pwr.pa     = (s_d.st == rpmc_pkg::ST_RUP) | (s_d.st == rpmc_pkg::ST_TX)
                          | (s_d.st == rpmc_pkg::ST_RDN);
         s_d.pwr.rx     = (s_d.st == rpmc_pkg::ST_RX);
         s_d.pwr.osc32  = s_d.mode[rpmc_pkg::MB_WT] | (s_d.opt[rpmc_pkg::OB_OSC]
                          & (s_d.mode[rpmc_pkg::MB_SENS] | s_d.pwr.xtal));
         s_d.pwr.aux    = s_d.mode[rpmc_pkg::MB_SENS] | (s_d.opt[rpmc_pkg::OB_AUX]
                          & (s_d.mode[rpmc_pkg::MB_WT] | s_d.pwr.xtal));
      end
   end

   // State register
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         s_q        <= '0;
         s_q.st     <= rpmc_pkg::ST_IDLE;
         s_q.mode   <= rpmc_pkg::MODE_RST;
         s_q.pa_lvl <= rpmc_pkg::PA_RST;
      end
      else
         s_q <= s_d;
   end

   // Outputs
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign HRDATA    = s_q.rdata;
   assign TX_MOD    = s_q.tx_mod;
   assign PWR       = s_q.pwr;
   assign PA_LEVEL  = s_q.pa_lvl;
   assign PA_RAMP   = s_q.ramp;
   assign GPIO_O    = s_q.gpio_o;
   assign GPIO_OE   = {s_q.gp_oe[2:1], s_q.gp_oe[0] | s_q.opt[rpmc_pkg::OB_ROUTE]};
endmodule // rpmc_top

// file: rpmc_top_chk.sv
`timescale 1ns/1ps
// Watches the mode controller at its pins
module rpmc_chk (
   input wire logic                CLOCK,
   input wire logic                ARST_N,
   input wire logic                HREADYOUT,
   input wire logic                HRESP,
   input wire logic                SHUTDOWN_PIN,
   input wire logic                RX_READY,
   input wire logic [2:0]          TX_MOD,
   input wire rpmc_pkg::rpmc_pwr_s PWR,
   input wire logic [7:0]          PA_RAMP
);
   // One clock domain, one reset
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   a_bus_no_wait: assert property (HREADYOUT && !HRESP)
      else $error("bus slave stalled or erred");
   a_shut_all_dark: assert property (SHUTDOWN_PIN [*5] |-> PWR == '0)
      else $error("blocks powered in shutdown");
   a_spi_domain_kept: assert property (!SHUTDOWN_PIN [*8] |-> PWR.spi)
      else $error("serial domain off outside shutdown");
   a_tx_rx_apart: assert property (!(PWR.pa && PWR.rx))
      else $error("amplifier and receiver both on");
   a_pa_chain_on: assert property (PWR.pa |-> PWR.pll && PWR.xtal && PWR.spi)
      else $error("amplifier on without its chain");
   a_rx_chain_on: assert property (PWR.rx |-> PWR.pll && PWR.xtal)
      else $error("receiver on without its chain");
   a_ramp_one_step: assert property ((!SHUTDOWN_PIN && !$past(SHUTDOWN_PIN, 4)
      && PA_RAMP != $past(PA_RAMP)) |-> (PA_RAMP - $past(PA_RAMP) == 8'h01)
      || ($past(PA_RAMP) - PA_RAMP == 8'h01))
      else $error("ramp jumped by more than one");
   a_ramp_capped: assert property (PA_RAMP <= 8'h14)
      else $error("ramp above full level");
   a_rx_quiet_tx: assert property (PWR.rx |-> PA_RAMP == 8'h00 && TX_MOD == 3'h0)
      else $error("transmit path active in receive");
   a_ready_low_rx: assert property (!RX_READY |-> PWR.rx)
      else $error("stream refused outside receive");
   a_mod_in_range: assert property (TX_MOD <= 3'h4)
      else $error("modulator value out of range");
   // Main scenarios reached
   c_tx_full: cover property (PA_RAMP == 8'h14);
   c_rx_on: cover property (PWR.rx);
   c_fifo_full: cover property (!RX_READY);
   c_shut: cover property (SHUTDOWN_PIN && PWR == '0);
endmodule // rpmc_chk

bind rpmc_top rpmc_chk rpmc_chk_i (.CLOCK(CLOCK), .ARST_N(ARST_N), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .SHUTDOWN_PIN(SHUTDOWN_PIN), .RX_READY(RX_READY), .TX_MOD(TX_MOD),
   .PWR(PWR), .PA_RAMP(PA_RAMP));

// file: rpmc_src.sv
`timescale 1ns/1ps
// Demodulator model: sends bytes 0,1,2.. up to count-1 while go is high
module rpmc_src (
   input  wire logic          clk,
   input  wire logic          arst_n,
   input  wire logic          go,
   input  wire logic [7:0]    count,
   input  wire logic          rx_ready,
   output rpmc_pkg::rpmc_byte_s rx_in,
   output logic [7:0]         sent
);
   // Byte held until taken; idle data toggles so it never looks stable
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_in <= '{1'b0, 8'hA5};
         sent  <= 8'h00;
      end
      else if (rx_in.valid && !rx_ready)
         rx_in <= rx_in;
      else
      begin
         sent  <= sent + {7'h0, rx_in.valid};
         rx_in.valid <= go && (sent + {7'h0, rx_in.valid} < count);
         rx_in.data  <= (go && (sent + {7'h0, rx_in.valid} < count)) ?
                        sent + {7'h0, rx_in.valid} : ~rx_in.data;
      end
   end
endmodule // rpmc_src

// file: tb.sv
`timescale 1ns/1ps
// Self-checking bench for the radio mode controller
module tb;
   logic        clock, arst_n, hsel, hwrite, shutdown_pin, rx_bit, tx_bit, go;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  gpio_i, gpio_o, gpio_oe, tx_mod, pa_level;
   logic [7:0]  pa_ramp, sent;
   logic        hreadyout, hresp, rx_ready;
   rpmc_pkg::rpmc_pwr_s  pwr;
   rpmc_pkg::rpmc_byte_s rx_in;
   int          n_mismatch, samples_checked;
   // Free running 100 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   rpmc_top rpmc_top_i (.CLOCK(clock), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
      .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .SHUTDOWN_PIN(shutdown_pin),
      .RX_IN(rx_in), .RX_READY(rx_ready), .RX_BIT(rx_bit), .TX_BIT(tx_bit), .TX_MOD(tx_mod),
      .PWR(pwr), .PA_LEVEL(pa_level), .PA_RAMP(pa_ramp), .GPIO_I(gpio_i), .GPIO_O(gpio_o),
      .GPIO_OE(gpio_oe));
   rpmc_src rpmc_src_i (.clk(clock), .arst_n(arst_n), .go(go), .count(8'h46),
      .rx_ready(rx_ready), .rx_in(rx_in), .sent(sent));
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Address phase, held until the slave is ready
   task automatic aph(input logic [7:0] a, input logic w);
      @(posedge clock);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
   endtask
   // Single word write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      aph(a, 1'b1);
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
   endtask
   // Single word read compared with expectation
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      aph(a, 1'b0);
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk(rd, exp);
   endtask
   // Let n edges pass, then sample at the falling edge
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   // State straight after reset
   task automatic t_reset;
      rchk(rpmc_pkg::A_MODE, 32'h1);
      rchk(rpmc_pkg::A_PA, 32'h7);
      rchk(8'h20, 32'h0);
      rchk(rpmc_pkg::A_STAT, 32'h3C8);
      chk({pwr.spi, pwr.xtal, pwr.pll, pwr.pa, pwr.rx}, 32'h18);
      $display("reset test done");
   endtask
   // Every idle mode, with and without optional blocks
   task automatic t_modes;
      logic [7:0] md [8] = '{8'h00, 8'h40, 8'h20, 8'h01, 8'h02, 8'h01, 8'h40, 8'h00};
      logic [3:0] op [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h3, 4'h2, 4'h3};
      logic [4:0] ex [8] = '{5'h10, 5'h18, 5'h14, 5'h12, 5'h13, 5'h1E, 5'h1C, 5'h10};
      for (int i = 0; i < 8; i++)
      begin
         wr(rpmc_pkg::A_OPT, {28'h0, op[i]});
         wr(rpmc_pkg::A_MODE, {24'h0, md[i]});
         settle(4);
         chk({pwr.spi, pwr.osc32, pwr.aux, pwr.xtal, pwr.pll}, ex[i]);
         rchk(rpmc_pkg::A_MODE, {24'h0, md[i]});
      end
      $display("mode test done");
   endtask
   // Standby to transmit, shaping, power step, back to ready
   task automatic t_tx;
      wr(rpmc_pkg::A_OPT, 32'h4);
      wr(rpmc_pkg::A_MODE, 32'h8);
      for (int i = 0; i < 400 && pa_ramp !== 8'h14; i++) @(negedge clock);
      chk(pa_ramp, 32'h14);
      chk({pwr.pa, pwr.rx}, 32'h2);
      wr(rpmc_pkg::A_PA, 32'h3);
      settle(2);
      chk(pa_level, 32'h3);
      repeat (8) @(posedge clock) tx_bit <= ~tx_bit;
      @(negedge clock);
      chk(tx_mod, 32'h2);
      wr(rpmc_pkg::A_OPT, 32'h0);
      tx_bit <= 1'b1;
      settle(4);
      chk(tx_mod, 32'h4);
      wr(rpmc_pkg::A_MODE, 32'h1);
      for (int i = 0; i < 100 && pa_ramp !== 8'h00; i++) @(negedge clock);
      settle(2);
      chk({pa_ramp, pwr.pa}, 32'h0);
      $display("transmit test done");
   endtask
   // Receive: fill the FIFO until refused, drain in order
   task automatic t_rx;
      wr(rpmc_pkg::A_MODE, 32'h5);
      for (int i = 0; i < 300 && pwr.rx !== 1'b1; i++) @(negedge clock);
      chk({pwr.rx, pwr.pa}, 32'h2);
      @(posedge clock);
      go <= 1'b1;
      for (int i = 0; i < 300 && rx_ready !== 1'b0; i++) @(negedge clock);
      settle(4);
      chk({rx_ready, sent}, 32'h40);
      for (int i = 0; i < 70; i++) rchk(rpmc_pkg::A_RXD, 32'h100 | i);
      rchk(rpmc_pkg::A_RXD, 32'h0);
      go <= 1'b0;
      $display("receive test done");
   endtask
   // Pins: direct drive, levels, receive data routed to pin 0
   task automatic t_gpio;
      wr(rpmc_pkg::A_GPIO, 32'h3D);
      settle(2);
      chk({gpio_oe, gpio_o}, 32'h3D);
      rchk(rpmc_pkg::A_GPIO, 32'h1BD);
      wr(rpmc_pkg::A_GPIO, 32'h0);
      wr(rpmc_pkg::A_OPT, 32'h8);
      for (int b = 1; b >= 0; b--)
      begin
         @(posedge clock) rx_bit <= b[0];
         settle(2);
         chk({gpio_oe[0], gpio_o[0]}, {30'h0, 1'b1, b[0]});
      end
      wr(rpmc_pkg::A_OPT, 32'h0);
      $display("pin test done");
   endtask
   // Software reset, then shutdown and wake
   task automatic t_shut;
      wr(rpmc_pkg::A_PA, 32'h2);
      wr(rpmc_pkg::A_MODE, 32'h80);
      rchk(rpmc_pkg::A_MODE, 32'h1);
      rchk(rpmc_pkg::A_PA, 32'h7);
      wr(rpmc_pkg::A_PA, 32'h2);
      @(posedge clock) shutdown_pin <= 1'b1;
      settle(6);
      chk(pwr, 32'h0);
      rchk(rpmc_pkg::A_MODE, 32'h0);
      wr(rpmc_pkg::A_MODE, 32'h40);
      @(posedge clock) shutdown_pin <= 1'b0;
      settle(8);
      rchk(rpmc_pkg::A_MODE, 32'h1);
      rchk(rpmc_pkg::A_PA, 32'h7);
      chk(pwr.spi, 32'h1);
      $display("shutdown test done");
   endtask
   // Counts, verdict, end of run
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      {arst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {shutdown_pin, rx_bit, tx_bit, go} = '0;
      gpio_i = 3'h6;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      t_reset;
      t_modes;
      t_tx;
      t_rx;
      t_gpio;
      t_shut;
      end_of_test;
   end
   // Watchdog far beyond the fewer than a thousand cycles the tests need
   initial
   begin
      #500000;
      n_mismatch++;
      end_of_test;
   end
endmodule // tb
